// [src/hse_engine.sv]
// hse_engine: rule table, rule actions and suppress/restore byte path
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`default_nettype none
module hse_engine import hse_pkg::*; (
   input wire logic core_clk, // clock
   input wire logic rst_n, // async reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic in_valid, // packet byte valid
   output logic in_ready, // packet byte ready
   input wire logic [7:0] in_data, // packet byte
   input wire logic in_last, // last byte of packet
   input wire logic [HSE_SLOT_W-1:0] in_slot, // rule slot of packet
   input wire logic in_suppressed, // receive: packet arrived suppressed
   output logic out_valid, // output byte valid
   input wire logic out_ready, // output byte ready
   output logic [7:0] out_data, // output byte
   output logic out_last, // last output byte
   output logic out_suppressed // send: packet left suppressed
);
   hse_state_s s;
   hse_state_s nxt_s;

   function automatic logic [31:0] hse_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   assign s_axi_awready = !s.aw_held;
   assign s_axi_wready = !s.w_held;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign out_valid = s.ov;
   assign out_data = s.od;
   assign out_last = s.ol;
   assign out_suppressed = s.osup;

   always_comb begin
      hse_rule_s r;
      hse_rule_s cr;
      logic [31:0] wv;
      logic [31:0] rd;
      logic [7:0] wa;
      logic [7:0] flow;
      logic [7:0] idx;
      logic [7:0] code;
      logic [7:0] sub;
      logic [HSE_SLOT_W-1:0] hs;
      logic [HSE_SLOT_W-1:0] fs;
      logic [HSE_SLOTS-1:0] used_v;
      logic [HSE_SLOTS-1:0] def_v;
      logic hit;
      logic free;
      logic wr_go;
      logic can_push;
      logic meff;
      logic keep;
      logic usable;
      logic push;
      logic [7:0] pd;
      logic pl;
      hse_act_e act;
      r = '0;
      cr = '0;
      wv = '0;
      rd = '0;
      wa = {s.aw_addr[7:2], 2'b00};
      flow = '0;
      idx = '0;
      code = CC_OK;
      sub = '0;
      hs = '0;
      fs = '0;
      used_v = '0;
      def_v = '0;
      hit = 1'b0;
      free = 1'b0;
      push = 1'b0;
      pd = '0;
      pl = 1'b0;
      keep = 1'b0;
      usable = 1'b0;
      wr_go = 1'b0;
      can_push = 1'b0;
      meff = 1'b0;
      act = ACT_ADD;
      nxt_s = s;
      in_ready = 1'b0;
      // ***********************************************
      // register bus
      // ***********************************************
      if (s.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_axi_awvalid && !s.aw_held) begin
         nxt_s.aw_held = 1'b1;
         nxt_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_held) begin
         nxt_s.w_held = 1'b1;
         nxt_s.w_data = s_axi_wdata;
         nxt_s.w_strb = s_axi_wstrb;
      end
      wr_go = s.aw_held && s.w_held && !s.bvalid;
      if (wr_go) begin
         nxt_s.aw_held = 1'b0;
         nxt_s.w_held = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = RESP_OKAY;
         case (wa)
            OFS_CMD: wv = hse_merge(32'h0, s.w_data, s.w_strb);
            OFS_SIZE: nxt_s.st_size = 9'(hse_merge({23'h0, s.st_size}, s.w_data, s.w_strb));
            OFS_MASK: nxt_s.st_mask = 17'(hse_merge({15'h0, s.st_mask}, s.w_data, s.w_strb));
            OFS_VERIFY: nxt_s.st_verify =
               9'(hse_merge({23'h0, s.st_verify}, s.w_data, s.w_strb));
            OFS_ENC: nxt_s.st_enc = hse_merge(s.st_enc, s.w_data, s.w_strb);
            OFS_CTRL: nxt_s.ctrl = 3'(hse_merge({29'h0, s.ctrl}, s.w_data, s.w_strb));
            OFS_ERR, OFS_STATUS: begin
            end
            default: begin
               if (wa >= OFS_BYTES && wa <= OFS_BYTES_END) begin
                  nxt_s.st_bytes[wa[3:2]] = hse_merge(s.st_bytes[wa[3:2]], s.w_data, s.w_strb);
               end else begin
                  nxt_s.bresp = RESP_SLVERR;
               end
            end
         endcase
      end
      // ***********************************************
      // rule actions
      // ***********************************************
      flow = wv[23:16];
      idx = wv[15:8];
      act = hse_act_e'(wv[1:0]);
      for (int i = 0; i < HSE_SLOTS; i++) begin
         if (s.tbl[i].used && s.tbl[i].flow == flow && s.tbl[i].index == idx && !hit) begin
            hit = 1'b1;
            hs = HSE_SLOT_W'(i);
         end
         if (!s.tbl[i].used && !free) begin
            free = 1'b1;
            fs = HSE_SLOT_W'(i);
         end
      end
      if (wr_go && wa == OFS_CMD) begin
         // a malformed vendor container is dropped; the rule itself still goes ahead
         if (s.st_enc[17] && !s.st_enc[18]) begin
            nxt_s.vendor_drop = s.vendor_drop + 8'h01;
         end
         case (act)
            ACT_ADD: begin
               if (hit) begin
                  code = CC_EXISTS;
                  sub = SUB_INDEX;
               end else if (!free) begin
                  code = CC_TEMP;
                  sub = SUB_INDEX;
               end
               r.used = 1'b1;
               r.flow = flow;
               r.index = idx;
            end
            ACT_SET: begin
               r = s.tbl[hs];
               if (!hit) begin
                  code = CC_NOT_FOUND;
                  sub = SUB_INDEX;
               end else if (r.has_size && s.st_size[8]) begin
                  code = CC_INVALID;
                  sub = SUB_SIZE;
               end else if (r.has_bytes && s.st_enc[16]) begin
                  code = CC_INVALID;
                  sub = SUB_BYTES;
               end else if (r.has_mask && s.st_mask[16]) begin
                  code = CC_INVALID;
                  sub = SUB_MASK;
               end else if (r.has_verify && s.st_verify[8]) begin
                  code = CC_INVALID;
                  sub = SUB_VERIFY;
               end
            end
            ACT_DEL: begin
               if (!hit) begin
                  code = CC_NOT_FOUND;
                  sub = SUB_INDEX;
               end else begin
                  nxt_s.tbl[hs] = '0;
               end
            end
            default: begin
               for (int i = 0; i < HSE_SLOTS; i++) begin
                  if (s.tbl[i].flow == flow) begin
                     nxt_s.tbl[i] = '0;
                  end
               end
            end
         endcase
         if (act == ACT_ADD || act == ACT_SET) begin
            if (!r.has_size && s.st_size[8]) begin
               r.has_size = 1'b1;
               r.size = s.st_size[7:0];
            end
            if (!r.has_bytes && s.st_enc[16]) begin
               r.has_bytes = 1'b1;
               r.nbytes = s.st_enc[31:24];
               for (int j = 0; j < HSE_MAXB; j++) begin
                  r.bytes[j] = s.st_bytes[j/4][(31-8*(j%4)) -: 8];
               end
            end
            if (!r.has_mask && s.st_mask[16]) begin
               r.has_mask = 1'b1;
               for (int j = 0; j < HSE_MAXB; j++) begin
                  r.mask[j] = s.st_mask[15-j];
               end
            end
            if (!r.has_verify && s.st_verify[8]) begin
               r.has_verify = 1'b1;
               r.skip = s.st_verify[0];
            end
            if (code == CC_OK) begin
               if (s.st_enc[8:0] >= ENC_LIMIT) begin
                  code = CC_INVALID;
                  sub = SUB_BYTES;
               end else if (idx == 8'h00) begin
                  code = CC_INVALID;
                  sub = SUB_INDEX;
               end else if (r.size > 8'(HSE_MAXB)) begin
                  code = CC_HS;
                  sub = SUB_SIZE;
               end else if (r.has_size && r.has_bytes && r.nbytes != r.size) begin
                  code = CC_INVALID;
                  sub = SUB_BYTES;
               end
            end
            if (code == CC_OK) begin
               nxt_s.tbl[(act == ACT_ADD) ? fs : hs] = r;
            end
         end
         nxt_s.err_present = (code != CC_OK);
         nxt_s.err_code = code;
         nxt_s.err_sub = sub;
      end
      // ***********************************************
      // register reads
      // ***********************************************
      for (int i = 0; i < HSE_SLOTS; i++) begin
         used_v[i] = s.tbl[i].used;
         def_v[i] = s.tbl[i].used && s.tbl[i].has_size && s.tbl[i].has_bytes;
      end
      if (s.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s.rvalid) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            OFS_CMD: rd = 32'h0;
            OFS_SIZE: rd = {23'h0, s.st_size};
            OFS_MASK: rd = {15'h0, s.st_mask};
            OFS_VERIFY: rd = {23'h0, s.st_verify};
            OFS_ENC: rd = s.st_enc;
            // no error text is ever attached, so its flag stays low
            OFS_ERR: rd = {7'h0, !s.err_present, 6'h0, 1'b0, s.err_present,
                           s.err_code, s.err_sub};
            OFS_STATUS: rd = {8'h0, s.vendor_drop, 4'h0, def_v, 4'h0, used_v};
            OFS_CTRL: rd = {29'h0, s.ctrl};
            default: begin
               if (s_axi_araddr >= OFS_BYTES && s_axi_araddr <= OFS_BYTES_END + 8'h03) begin
                  rd = s.st_bytes[s_axi_araddr[3:2]];
               end else begin
                  nxt_s.rresp = RESP_SLVERR;
               end
            end
         endcase
         nxt_s.rdata = rd;
      end
      // ***********************************************
      // byte path
      // ***********************************************
      // the table may change under a packet in flight; software should pause traffic
      cr = s.tbl[s.slot];
      can_push = !s.ov || out_ready;
      meff = cr.has_mask ? cr.mask[s.cnt[3:0]] : 1'b1;
      if (s.ov && out_ready) begin
         nxt_s.ov = 1'b0;
      end
      case (s.st)
         ST_IDLE: begin
            if (in_valid) begin
               r = s.tbl[in_slot];
               usable = s.ctrl[0] && r.used && r.has_size && r.has_bytes;
               usable = usable && (r.size != 8'h00) && (!s.ctrl[2] || in_suppressed);
               nxt_s.slot = in_slot;
               nxt_s.cnt = '0;
               nxt_s.mism = 1'b0;
               nxt_s.lastin = 1'b0;
               nxt_s.psup = 1'b0;
               if (!usable) begin
                  nxt_s.st = ST_PASS;
               end else if (s.ctrl[1]) begin
                  nxt_s.st = ST_OFFS;
               end else begin
                  nxt_s.st = s.ctrl[2] ? ST_RESTORE : ST_GATHER;
               end
            end
         end
         ST_OFFS: begin
            in_ready = can_push;
            if (in_valid && can_push) begin
               push = 1'b1;
               pd = in_data;
               pl = in_last;
               nxt_s.cnt = s.cnt + 5'h01;
               if (in_last) begin
                  nxt_s.st = ST_IDLE;
               end else if (s.cnt == DS_OFFSET - 5'h01) begin
                  nxt_s.cnt = '0;
                  nxt_s.st = s.ctrl[2] ? ST_RESTORE : ST_GATHER;
               end
            end
         end
         ST_GATHER: begin
            in_ready = 1'b1;
            if (in_valid) begin
               nxt_s.buf_b[s.cnt[3:0]] = in_data;
               if (meff && !cr.skip && in_data != cr.bytes[s.cnt[3:0]]) begin
                  nxt_s.mism = 1'b1;
               end
               nxt_s.cnt = s.cnt + 5'h01;
               if (in_last || {3'h0, s.cnt} == cr.size - 8'h01) begin
                  // a packet ending inside the window always leaves whole
                  nxt_s.lastin = in_last;
                  nxt_s.n = s.cnt + 5'h01;
                  nxt_s.cnt = '0;
                  nxt_s.st = ST_EMIT;
               end
            end
         end
         ST_EMIT: begin
            keep = s.mism || s.lastin || !meff;
            nxt_s.psup = !(s.mism || s.lastin);
            if (!keep || can_push) begin
               push = keep;
               pd = s.buf_b[s.cnt[3:0]];
               pl = s.lastin && (s.cnt == s.n - 5'h01);
               nxt_s.cnt = s.cnt + 5'h01;
               if (s.cnt == s.n - 5'h01) begin
                  nxt_s.st = s.lastin ? ST_IDLE : ST_PASS;
               end
            end
         end
         ST_RESTORE: begin
            if (meff) begin
               if (can_push) begin
                  push = 1'b1;
                  pd = cr.bytes[s.cnt[3:0]];
                  nxt_s.cnt = s.cnt + 5'h01;
                  if ({3'h0, s.cnt} == cr.size - 8'h01) begin
                     nxt_s.st = ST_PASS;
                  end
               end
            end else begin
               in_ready = can_push;
               if (in_valid && can_push) begin
                  push = 1'b1;
                  pd = in_data;
                  pl = in_last;
                  nxt_s.cnt = s.cnt + 5'h01;
                  if (in_last) begin
                     nxt_s.st = ST_IDLE;
                  end else if ({3'h0, s.cnt} == cr.size - 8'h01) begin
                     nxt_s.st = ST_PASS;
                  end
               end
            end
         end
         ST_PASS: begin
            in_ready = can_push;
            if (in_valid && can_push) begin
               push = 1'b1;
               pd = in_data;
               pl = in_last;
               if (in_last) begin
                  nxt_s.st = ST_IDLE;
               end
            end
         end
         default: nxt_s.st = ST_IDLE;
      endcase
      if (push) begin
         nxt_s.ov = 1'b1;
         nxt_s.od = pd;
         nxt_s.ol = pl;
         nxt_s.osup = !s.ctrl[2] && (s.st == ST_EMIT ? !(s.mism || s.lastin) : s.psup);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= nxt_s;
      end
   end
endmodule
`default_nettype wire

// [pkg/hse_pkg.sv]
// hse_pkg: constants and types of the header suppression engine
// Notes on behaviour
// - Action byte: 0 add, 1 set, 2 delete, 3 delete all; apply it.
// - Set only fills missing fields; never alters a field already present.
// - No suppression until both size and cached bytes are known.
// - Add of an existing rule is rejected and the stored rule kept.
// - Delete all clears only the rules of the named flow.
// - Error set only for rejected requests; none on success.
// - A response with an error set carries no other suppression encodings.
// - Error set holds one errored-parameter byte naming the subtype.
// - Error set holds one nonzero confirmation code.
// - At most one zero-terminated error text; its length counts the zero.
// - Whole suppression encoding is shorter than 256 bytes.
// - Window starts right after checksum upstream, at 13th byte downstream.
// - Most significant cached byte maps to the first window byte.
// - Cached byte count equals the rule size.
// - Index runs 1 to 255, unique per flow.
// - Mask bit 0 is the MSB and governs the first window byte.
// - Mask 1: sender drops, receiver reinserts; mask 0: byte travels.
// - An absent mask means every window byte is suppressed.
// - Size zero disables suppression; nonzero suppresses that many bytes.
// - Verify flag 0 verifies (default); sender sends unsuppressed on mismatch.
// - Vendor container discarded unless its first element is a vendor id.
// - Add on an existing rule answers confirmation code 17.
`default_nettype none
package hse_pkg;
   localparam int HSE_SLOTS = 4;
   localparam int HSE_MAXB = 16;
   localparam int HSE_SLOT_W = 2;
   localparam int HSE_CNT_W = 5;
   // ***********************************************
   // register byte offsets
   // ***********************************************
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_SIZE = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_VERIFY = 8'h0c;
   localparam logic [7:0] OFS_ENC = 8'h10;
   localparam logic [7:0] OFS_ERR = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_CTRL = 8'h1c;
   localparam logic [7:0] OFS_BYTES = 8'h20;
   localparam logic [7:0] OFS_BYTES_END = 8'h2c;
   // ***********************************************
   // codes and counts
   // ***********************************************
   localparam logic [7:0] CC_OK = 8'h00;
   localparam logic [7:0] CC_TEMP = 8'h03;
   localparam logic [7:0] CC_HS = 8'h09;
   localparam logic [7:0] CC_NOT_FOUND = 8'h10;
   localparam logic [7:0] CC_EXISTS = 8'h11;
   localparam logic [7:0] CC_INVALID = 8'h17;
   localparam logic [7:0] SUB_BYTES = 8'h07;
   localparam logic [7:0] SUB_INDEX = 8'h08;
   localparam logic [7:0] SUB_MASK = 8'h09;
   localparam logic [7:0] SUB_SIZE = 8'h0a;
   localparam logic [7:0] SUB_VERIFY = 8'h0b;
   localparam logic [8:0] ENC_LIMIT = 9'h100;
   localparam logic [4:0] DS_OFFSET = 5'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ACT_ADD = 2'h0, ACT_SET = 2'h1, ACT_DEL = 2'h2, ACT_DEL_ALL = 2'h3
   } hse_act_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_OFFS = 3'h1, ST_GATHER = 3'h3, ST_EMIT = 3'h2,
      ST_PASS = 3'h6, ST_RESTORE = 3'h7
   } hse_st_e;
   typedef struct packed {
      logic used;
      logic [7:0] flow;
      logic [7:0] index;
      logic has_size;
      logic [7:0] size;
      logic has_bytes;
      logic [7:0] nbytes;
      logic [HSE_MAXB-1:0][7:0] bytes;
      logic has_mask;
      logic [HSE_MAXB-1:0] mask;
      logic has_verify;
      logic skip;
   } hse_rule_s;
   typedef struct packed {
      hse_rule_s [HSE_SLOTS-1:0] tbl;
      logic [8:0] st_size;
      logic [16:0] st_mask;
      logic [8:0] st_verify;
      logic [31:0] st_enc;
      logic [3:0][31:0] st_bytes;
      logic [2:0] ctrl;
      logic err_present;
      logic [7:0] err_sub;
      logic [7:0] err_code;
      logic [7:0] vendor_drop;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      hse_st_e st;
      logic [HSE_SLOT_W-1:0] slot;
      logic [HSE_CNT_W-1:0] cnt;
      logic [HSE_CNT_W-1:0] n;
      logic mism;
      logic lastin;
      logic psup;
      logic [HSE_MAXB-1:0][7:0] buf_b;
      logic ov;
      logic [7:0] od;
      logic ol;
      logic osup;
   } hse_state_s;
endpackage
`default_nettype wire

// [bench/hse_monitor.sv]
// port checker of the header suppression engine
`default_nettype none
module hse_monitor import hse_pkg::*; (
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [7:0] s_axi_araddr, // ar addr
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic out_valid, // byte valid
   input wire logic out_ready, // byte ready
   input wire logic [7:0] out_data // byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ra_ff;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ra_ff <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         ra_ff <= s_axi_araddr;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence wr_both_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_err_s;
      s_axi_rvalid && ra_ff == OFS_ERR;
   endsequence
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output byte changed while stalled");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed while stalled");
   r_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not cleared after acceptance");
   wr_answer_a: assert property (wr_both_s |-> ##2 s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   err_code_a: assert property (rd_err_s ##0 s_axi_rdata[16] |->
      s_axi_rdata[15:8] != CC_OK)
      else $error("error set with zero code");
   err_excl_a: assert property (rd_err_s |-> s_axi_rdata[24] == !s_axi_rdata[16])
      else $error("other encodings allowed beside error set");
endmodule
bind hse_engine hse_monitor mon (.*);
`default_nettype wire

// [bench/hse_sink.sv]
// byte sink beyond the engine; stalls one cycle in four
`default_nettype none
module hse_sink (
   input wire logic core_clk, // clock
   input wire logic out_valid, // byte valid
   input wire logic [7:0] out_data, // byte
   input wire logic out_suppressed, // left suppressed
   input wire logic out_last, // last byte
   output logic out_ready // accept
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got [0:63];
   logic sup [0:63];
   logic lst [0:63];
   int n = 0;
   logic [1:0] ph = 2'h0;
   initial out_ready = 1'b0;
   always @(posedge core_clk) begin
      if (out_valid && out_ready) begin
         got[n] = out_data;
         sup[n] = out_suppressed;
         lst[n] = out_last;
         n++;
      end
      ph <= ph + 2'h1;
      out_ready <= (ph != 2'h2);
   end
endmodule
`default_nettype wire

// [bench/tb_payload_header_suppression_engine.sv]
// self-checking bench of the header suppression engine
`default_nettype none
module tb_payload_header_suppression_engine import hse_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic in_valid = 1'b0, in_last = 1'b0, in_suppressed = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, in_data = 8'h00, out_data;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] in_slot = 2'h0, s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic in_ready, out_valid, out_ready, out_last, out_suppressed;
   int fails = 0, checks_done = 0;
   hse_engine dut (.*);
   hse_sink sink (.*);
   always #25 core_clk = ~core_clk;
   // ***************************
   // bus and stream tasks
   // ***************************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, td;
      ta = 1'b0;
      td = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && td)) begin
         @(posedge core_clk);
         ta |= s_axi_awready;
         td |= s_axi_wready;
         s_axi_awvalid <= !ta;
         s_axi_wvalid <= !td;
      end
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(nm, v, e);
   endtask
   task pkt(input logic [7:0] b[$], input logic [7:0] e[$], input logic es);
      int base, i;
      base = sink.n;
      @(posedge core_clk);
      foreach (b[k]) begin
         in_valid <= 1'b1;
         in_data <= b[k];
         in_last <= (k == b.size() - 1);
         do @(posedge core_clk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
      for (i = 0; i < 100 && sink.n - base < e.size(); i++) @(posedge core_clk);
      chk("count", 32'(sink.n - base), 32'(e.size()));
      foreach (e[k]) begin
         chk("byte", {24'h0, sink.got[base + k]}, {24'h0, e[k]});
         chk("sup", {31'h0, sink.sup[base + k]}, {31'h0, es});
         chk("last", {31'h0, sink.lst[base + k]}, {31'h0, k == e.size() - 1});
      end
   endtask
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      end_sim;
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rc(OFS_CTRL, 32'h0, "ctrl");
      rc(OFS_ERR, 32'h01000000, "err");
      rc(8'h40, 32'h0, "unmapped");
      // two-byte rule, no mask given, verify by default
      wr(OFS_SIZE, 32'h102);
      wr(OFS_ENC, 32'h0201000a);
      wr(OFS_BYTES, 32'habcd0000);
      wr(OFS_CMD, 32'h00050100);
      rc(OFS_ERR, 32'h01000000, "add");
      rc(OFS_STATUS, 32'h101, "status");
      wr(OFS_CMD, 32'h00050100);
      rc(OFS_ERR, 32'h00011108, "add twice");
      wr(OFS_CMD, 32'h00050101);
      rc(OFS_ERR, 32'h0001170a, "set");
      wr(OFS_CMD, 32'h00050000);
      rc(OFS_ERR, 32'h00011708, "index zero");
      wr(OFS_CMD, 32'h00050902);
      rc(OFS_ERR, 32'h00011008, "delete");
      wr(OFS_CMD, 32'h00060100);
      wr(OFS_CTRL, 32'h1);
      pkt('{8'hab, 8'hcd, 8'h11, 8'h22}, '{8'h11, 8'h22}, 1'b1);
      pkt('{8'hab, 8'hce, 8'h33}, '{8'hab, 8'hce, 8'h33}, 1'b0);
      wr(OFS_CMD, 32'h00050003);
      rc(OFS_STATUS, 32'h202, "delete all");
      pkt('{8'hab, 8'hcd, 8'h44}, '{8'hab, 8'hcd, 8'h44}, 1'b0);
      // size zero rule in slot 0, its vendor container lacks the id
      wr(OFS_SIZE, 32'h100);
      wr(OFS_ENC, 32'h0003000a);
      wr(OFS_CMD, 32'h00070100);
      rc(OFS_STATUS, 32'h10303, "size zero");
      wr(OFS_CTRL, 32'h5);
      in_suppressed <= 1'b1;
      pkt('{8'h66, 8'h77}, '{8'h66, 8'h77}, 1'b0);
      // receive downstream on slot 1: twelve bytes pass, then the window is rebuilt
      wr(OFS_CTRL, 32'h7);
      in_slot <= 2'h1;
      pkt('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
            8'h0c, 8'h55},
          '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
            8'h0c, 8'hab, 8'hcd, 8'h55}, 1'b0);
      end_sim;
   end
endmodule
`default_nettype wire
